// >>> logic/pdeo_override.sv
`timescale 1ns/1ps
`default_nettype none
// Function
// - timer1 compare A reaches port D pin 2 only when direction is output
// - that pin also carries timer1 PWM waveform
// - SPI master forces alternate data-in pin to input
// - SPI slave lets pin 2 direction follow its direction bit
// - forced-input pin 2 pull-up follows its value bit
// - clock-output fuse drives divided clock on pin 1, overriding bits
// - divided clock also driven during chip reset
// - SPI slave forces slave-select pin 0 to input unless PSC0 output is enabled
// - SPI slave active only while slave-select is low
// - SPI master lets pin 0 direction follow its direction bit
// - forced-input pin 0 pull-up follows pin 0 value bit
// - pin 0 direction override on PSC0 output enable or SPI term
// - oscillator output pin not I/O when crystal clock used
// - oscillator input pin not I/O except for internal RC clock
// - timer0 compare B drives port E pin 1 only when output
// - reset-disable fuse programmed makes port E pin 0 normal I/O
// - fuse unprogrammed connects reset circuit to pin 0, no I/O
// - as reset pin, its direction, value and input read zero
module pdeo_override
	import pdeo_pkg::*;
#(
	parameter int PORT_WIDTH = 3
) (
	// clocking
	input  wire logic                       clk_sys,
	input  wire logic                       rst,
	input  wire logic                       clk_en,
	// port D registers, low bits
	input  wire logic [PORT_WIDTH-1:0]      portd_dir,
	input  wire logic [PORT_WIDTH-1:0]      portd_value,
	// port E registers
	input  wire logic [PORT_WIDTH-1:0]      porte_dir,
	input  wire logic [PORT_WIDTH-1:0]      porte_value,
	// fuses and clock selection
	input  wire logic                       clock_output_fuse,
	input  wire logic                       reset_pin_disable_fuse,
	input  wire pdeo_pkg::pdeo_clk_src_type clk_source,
	input  wire logic                       chip_in_reset,
	input  wire logic                       divided_clock_out,
	// spi controls
	input  wire logic                       spi_unit_enable,
	input  wire logic                       spi_master_select,
	input  wire logic                       spi_pin_select,
	input  wire logic                       spi_miso_out,
	// timers and psc
	input  wire logic                       timer1_compare_a_out,
	input  wire logic                       timer1_compare_a_enable,
	input  wire logic                       timer0_compare_b_out,
	input  wire logic                       timer0_compare_b_enable,
	input  wire logic                       psc0_output0,
	input  wire logic                       psc0_output0_enable,
	// pads
	input  wire logic [PORT_WIDTH-1:0]      portd_pad_in,
	input  wire logic [PORT_WIDTH-1:0]      porte_pad_in,
	output var  logic [PORT_WIDTH-1:0]      portd_pad_out,
	output var  logic [PORT_WIDTH-1:0]      portd_pad_oe,
	output var  logic [PORT_WIDTH-1:0]      portd_pullup,
	output var  logic [PORT_WIDTH-1:0]      porte_pad_out,
	output var  logic [PORT_WIDTH-1:0]      porte_pad_oe,
	output var  logic [PORT_WIDTH-1:0]      porte_pullup,
	// read-back to port registers
	output var  logic [PORT_WIDTH-1:0]      portd_input,
	output var  logic [PORT_WIDTH-1:0]      porte_input,
	output var  logic [PORT_WIDTH-1:0]      porte_dir_read,
	output var  logic [PORT_WIDTH-1:0]      porte_value_read,
	// peripheral inputs
	output var  logic                       psc0_digital_in,
	output var  logic                       psc2_digital_in,
	output var  logic                       spi_miso_in,
	output var  logic                       spi_slave_selected,
	output var  logic                       external_reset_req,
	output var  logic                       osc_pins_claimed
);
	initial begin
		if (PORT_WIDTH != PORT_W) $error("pdeo_override serves exactly three pins per port");
	end

	logic [PORT_WIDTH-1:0] pd_sync;
	logic [PORT_WIDTH-1:0] pe_sync;

	genvar gi;
	generate
		for (gi = 0; gi < PORT_WIDTH; gi++) begin : g_sync
			pdeo_sync #(.STAGES(SYNC_STAGES)) u_pd (
				.clk_sys (clk_sys),
				.rst     (rst),
				.clk_en  (clk_en),
				.d_in    (portd_pad_in[gi]),
				.q_out   (pd_sync[gi])
			);
			pdeo_sync #(.STAGES(SYNC_STAGES)) u_pe (
				.clk_sys (clk_sys),
				.rst     (rst),
				.clk_en  (clk_en),
				.d_in    (porte_pad_in[gi]),
				.q_out   (pe_sync[gi])
			);
		end
	endgenerate

	// override terms
	logic spi_master_alt;
	logic spi_slave_alt;
	logic pd0_direction_override_enable;
	logic pd2_direction_override_enable;
	logic pd1_clk_on;
	logic pe0_is_reset;
	logic osc_out_claim;
	logic osc_in_claim;

	always_comb begin
		spi_master_alt = spi_unit_enable & spi_master_select & spi_pin_select;
		spi_slave_alt  = spi_unit_enable & ~spi_master_select & spi_pin_select;
		pd0_direction_override_enable       = psc0_output0_enable | spi_master_alt | spi_slave_alt;
		pd2_direction_override_enable       = spi_master_alt;
		pd1_clk_on     = clock_output_fuse | chip_in_reset;
		pe0_is_reset   = ~reset_pin_disable_fuse;
		osc_out_claim  = (clk_source == PDEO_CLK_CRYSTAL) || (clk_source == PDEO_CLK_LF_CRYSTAL);
		osc_in_claim   = (clk_source != PDEO_CLK_RC);
	end

	// port D pads
	logic [PORT_WIDTH-1:0] pd_oe_nxt;
	logic [PORT_WIDTH-1:0] pd_out_nxt;
	logic [PORT_WIDTH-1:0] pd_pu_nxt;

	always_comb begin
		pd_oe_nxt  = portd_dir;
		pd_out_nxt = portd_value;
		pd_pu_nxt  = ~portd_dir & portd_value;
		// pin 0: psc output or slave select
		if (pd0_direction_override_enable) begin
			pd_oe_nxt[PD_SS_A] = psc0_output0_enable;
			if (spi_master_alt && !psc0_output0_enable) begin
				pd_oe_nxt[PD_SS_A] = portd_dir[PD_SS_A];
			end
		end
		if (psc0_output0_enable) begin
			pd_out_nxt[PD_SS_A] = psc0_output0;
		end
		pd_pu_nxt[PD_SS_A] = ~pd_oe_nxt[PD_SS_A] & portd_value[PD_SS_A];
		// pin 1: divided clock
		if (pd1_clk_on) begin
			pd_oe_nxt[PD_DIVIDED_CLOCK_OUT]  = 1'b1;
			pd_out_nxt[PD_DIVIDED_CLOCK_OUT] = divided_clock_out;
			pd_pu_nxt[PD_DIVIDED_CLOCK_OUT]  = 1'b0;
		end
		// pin 2: timer1 compare A or alternate data-in
		if (pd2_direction_override_enable) begin
			pd_oe_nxt[PD_MISO_A] = 1'b0;
		end else if (spi_slave_alt) begin
			pd_oe_nxt[PD_MISO_A] = portd_dir[PD_MISO_A];
			pd_out_nxt[PD_MISO_A] = spi_miso_out;
		end
		if (timer1_compare_a_enable && !spi_slave_alt) begin
			pd_out_nxt[PD_MISO_A] = timer1_compare_a_out;
		end
		pd_pu_nxt[PD_MISO_A] = ~pd_oe_nxt[PD_MISO_A] & portd_value[PD_MISO_A];
	end

	// port E pads
	logic [PORT_WIDTH-1:0] pe_oe_nxt;
	logic [PORT_WIDTH-1:0] pe_out_nxt;
	logic [PORT_WIDTH-1:0] pe_pu_nxt;

	always_comb begin
		pe_oe_nxt  = porte_dir;
		pe_out_nxt = porte_value;
		pe_pu_nxt  = ~porte_dir & porte_value;
		if (timer0_compare_b_enable) begin
			pe_out_nxt[PE_OSC_IN] = timer0_compare_b_out;
		end
		if (osc_in_claim) begin
			pe_oe_nxt[PE_OSC_IN]  = 1'b0;
			pe_out_nxt[PE_OSC_IN] = 1'b0;
			pe_pu_nxt[PE_OSC_IN]  = 1'b0;
		end
		if (osc_out_claim) begin
			pe_oe_nxt[PE_OSC_OUT]  = 1'b0;
			pe_out_nxt[PE_OSC_OUT] = 1'b0;
			pe_pu_nxt[PE_OSC_OUT]  = 1'b0;
		end
		if (pe0_is_reset) begin
			pe_oe_nxt[PE_RST]  = 1'b0;
			pe_out_nxt[PE_RST] = 1'b0;
			pe_pu_nxt[PE_RST]  = 1'b0;
		end
	end

	// pad drive registers
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			portd_pad_oe  <= PAD_RST_VAL;
			portd_pad_out <= PAD_RST_VAL;
			portd_pullup  <= PAD_RST_VAL;
			porte_pad_oe  <= PAD_RST_VAL;
			porte_pad_out <= PAD_RST_VAL;
			porte_pullup  <= PAD_RST_VAL;
		end else if (clk_en) begin
			portd_pad_oe  <= pd_oe_nxt;
			portd_pad_out <= pd_out_nxt;
			portd_pullup  <= pd_pu_nxt;
			porte_pad_oe  <= pe_oe_nxt;
			porte_pad_out <= pe_out_nxt;
			porte_pullup  <= pe_pu_nxt;
		end
	end

	// read-back registers
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			portd_input      <= PAD_RST_VAL;
			porte_input      <= PAD_RST_VAL;
			porte_dir_read   <= PAD_RST_VAL;
			porte_value_read <= PAD_RST_VAL;
		end else if (clk_en) begin
			portd_input      <= pd_sync;
			porte_input      <= pe_sync;
			porte_dir_read   <= porte_dir;
			porte_value_read <= porte_value;
			if (osc_in_claim) begin
				porte_input[PE_OSC_IN] <= 1'b0;
			end
			if (osc_out_claim) begin
				porte_input[PE_OSC_OUT] <= 1'b0;
			end
			if (pe0_is_reset) begin
				porte_input[PE_RST]      <= 1'b0;
				porte_dir_read[PE_RST]   <= 1'b0;
				porte_value_read[PE_RST] <= 1'b0;
			end
		end
	end

	// peripheral input paths
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			psc0_digital_in    <= 1'b0;
			psc2_digital_in    <= 1'b0;
			spi_miso_in        <= 1'b0;
			spi_slave_selected <= 1'b0;
			external_reset_req <= 1'b0;
			osc_pins_claimed   <= 1'b0;
		end else if (clk_en) begin
			psc0_digital_in    <= pd_sync[PD_DIVIDED_CLOCK_OUT];
			psc2_digital_in    <= pd_sync[PD_MISO_A];
			spi_miso_in        <= pd_sync[PD_MISO_A] & spi_master_alt;
			spi_slave_selected <= spi_slave_alt & ~pd_sync[PD_SS_A];
			external_reset_req <= pe0_is_reset & ~pe_sync[PE_RST];
			osc_pins_claimed   <= osc_in_claim;
		end
	end
endmodule : pdeo_override
`default_nettype wire

// >>> include/pdeo_pkg.sv
`default_nettype none
package pdeo_pkg;
	// pin indices
	localparam int PD_SS_A    = 0;
	localparam int PD_DIVIDED_CLOCK_OUT    = 1;
	localparam int PD_MISO_A  = 2;
	localparam int PE_RST     = 0;
	localparam int PE_OSC_IN  = 1;
	localparam int PE_OSC_OUT = 2;
	localparam int PORT_W     = 3;
	// reset values
	localparam logic [2:0] PAD_RST_VAL = 3'h0;
	// synchroniser depth
	localparam int SYNC_STAGES = 3;
	// clock source selections
	typedef enum logic [1:0] {
		PDEO_CLK_RC,
		PDEO_CLK_CRYSTAL,
		PDEO_CLK_LF_CRYSTAL,
		PDEO_CLK_EXTERNAL
	} pdeo_clk_src_type;
endpackage : pdeo_pkg
`default_nettype wire

// >>> logic/pdeo_sync.sv
`timescale 1ns/1ps
`default_nettype none
module pdeo_sync #(
	parameter int STAGES = 3
) (
	// clocking
	input  wire logic clk_sys,
	input  wire logic rst,
	input  wire logic clk_en,
	// data
	input  wire logic d_in,
	output var  logic q_out
);
	initial begin
		if (STAGES != 3) $error("pdeo_sync needs exactly three stages");
	end

	logic [2:0] stage_r;

	// three flops, change accepted when last two agree
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			stage_r <= 3'h0;
		end else if (clk_en) begin
			stage_r <= {stage_r[1:0], d_in};
		end
	end

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			q_out <= 1'b0;
		end else if (clk_en && (stage_r[1] == stage_r[2])) begin
			q_out <= stage_r[2];
		end
	end
endmodule : pdeo_sync
`default_nettype wire

// >>> testbench/pdeo_override_sva.sv
`timescale 1ns/1ps
`default_nettype none
module pdeo_override_sva
	import pdeo_pkg::*;
(
	// controls
	input wire logic                       clk_sys,
	input wire logic                       rst,
	input wire logic                       clk_en,
	input wire logic                       clock_output_fuse,
	input wire logic                       reset_pin_disable_fuse,
	input wire pdeo_pkg::pdeo_clk_src_type clk_source,
	input wire logic                       spi_unit_enable,
	input wire logic                       spi_master_select,
	input wire logic                       spi_pin_select,
	input wire logic                       psc0_output0_enable,
	input wire logic [2:0]                 portd_dir,
	// pad side
	input wire logic [2:0]                 portd_pad_oe,
	input wire logic [2:0]                 porte_pad_oe,
	input wire logic [2:0]                 porte_dir_read,
	input wire logic [2:0]                 porte_value_read
);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (rst || !clk_en);
	sequence s_spi_alt;
		spi_unit_enable && spi_pin_select;
	endsequence
	a_divided_clock_out_drive: assert property (clock_output_fuse |=> portd_pad_oe[1]) else $error("clock pin idle");
	a_miso_master: assert property (s_spi_alt ##0 spi_master_select |=> !portd_pad_oe[2]) else $error("data pin on");
	a_miso_slave: assert property (s_spi_alt ##0 !spi_master_select |=> portd_pad_oe[2] == $past(portd_dir[2]))
		else $error("data pin dir");
	a_ss_slave: assert property (s_spi_alt ##0 !spi_master_select && !psc0_output0_enable |=> !portd_pad_oe[0])
		else $error("select pin on");
	a_ss_master: assert property (
		s_spi_alt ##0 spi_master_select && !psc0_output0_enable |=> portd_pad_oe[0] == $past(portd_dir[0]))
		else $error("select pin dir");
	a_psc_drive: assert property (psc0_output0_enable |=> portd_pad_oe[0]) else $error("psc pin idle");
	a_osc_out: assert property (clk_source inside {PDEO_CLK_CRYSTAL, PDEO_CLK_LF_CRYSTAL} |=> !porte_pad_oe[2])
		else $error("osc out on");
	a_osc_in: assert property (clk_source != PDEO_CLK_RC |=> !porte_pad_oe[1]) else $error("osc in on");
	a_reset_pin: assert property (
		!reset_pin_disable_fuse |=> !(porte_dir_read[0] || porte_value_read[0] || porte_pad_oe[0]))
		else $error("reset pin readable");
endmodule : pdeo_override_sva
bind pdeo_override pdeo_override_sva u_sva (.*);
`default_nettype wire

// >>> testbench/pdeo_pads.sv
`timescale 1ns/1ps
`default_nettype none
module pdeo_pads (
	// clock
	input  wire logic       clk_sys,
	// device side
	input  wire logic [2:0] pad_out,
	input  wire logic [2:0] pad_oe,
	input  wire logic [2:0] pu_en,
	// far side
	input  wire logic [2:0] ext_val,
	input  wire logic [2:0] ext_en,
	output var  logic [2:0] pad_in
);
	logic [2:0] last_r = 3'h0;
	always_ff @(posedge clk_sys) begin
		last_r <= pad_in;
	end
	// floating pin toggles
	always_comb begin
		for (int i = 0; i < 3; i++) begin
			pad_in[i] = pad_oe[i] ? pad_out[i] : ext_en[i] ? ext_val[i] : pu_en[i] ? 1'h1 : ~last_r[i];
		end
	end
endmodule : pdeo_pads
`default_nettype wire

// >>> testbench/pdeo_override_tb.sv
`timescale 1ns/1ps
`default_nettype none
module pdeo_override_tb;
	import pdeo_pkg::*;
	logic clk_sys = 1'h0;
	logic rst = 1'h1;
	logic clk_en = 1'h1;
	logic [2:0] portd_dir, portd_value, porte_dir, porte_value, portd_pad_in, porte_pad_in, d_ext, d_ext_en, e_ext;
	logic [2:0] portd_pad_out, portd_pad_oe, portd_pullup, porte_pad_out, porte_pad_oe, porte_pullup, e_ext_en;
	logic [2:0] portd_input, porte_input, porte_dir_read, porte_value_read;
	logic clock_output_fuse, reset_pin_disable_fuse, chip_in_reset, divided_clock_out, spi_unit_enable;
	logic spi_master_select, spi_pin_select, spi_miso_out, timer1_compare_a_out, timer1_compare_a_enable;
	logic timer0_compare_b_out, timer0_compare_b_enable, psc0_output0, psc0_output0_enable, psc0_digital_in;
	logic psc2_digital_in, spi_miso_in, spi_slave_selected, external_reset_req, osc_pins_claimed;
	pdeo_clk_src_type clk_source;
	int fail_count = 0;
	int compares = 0;
	always #5 clk_sys = ~clk_sys;
	pdeo_override #(.PORT_WIDTH(3)) dut (.*);
	pdeo_pads pads_d (.clk_sys, .pad_out(portd_pad_out), .pad_oe(portd_pad_oe), .pu_en(portd_pullup),
		.ext_val(d_ext), .ext_en(d_ext_en), .pad_in(portd_pad_in));
	pdeo_pads pads_e (.clk_sys, .pad_out(porte_pad_out), .pad_oe(porte_pad_oe), .pu_en(porte_pullup),
		.ext_val(e_ext), .ext_en(e_ext_en), .pad_in(porte_pad_in));
	task tick(input int n);
		repeat (n) @(posedge clk_sys);
		#1;
	endtask : tick
	task chk(input string nm, input logic [2:0] exp, input logic [2:0] got);
		compares++;
		if (got !== exp) begin
			fail_count++;
			$display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
		end
	endtask : chk
	task end_sim;
		$display("compares %0d fail_count %0d", compares, fail_count);
		if (fail_count == 0 && compares > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask : end_sim
	task t_plain;
		{portd_dir, portd_value, porte_dir, porte_value} = {3'h5, 3'h3, 3'h6, 3'h3};
		tick(2);
		chk("pd_oe", 3'h5, portd_pad_oe);
		chk("pd_out", 3'h1, portd_pad_out & portd_pad_oe);
		chk("pd_pu", 3'h2, portd_pullup);
		chk("pe_pu", 3'h1, porte_pullup);
		chk("pe_dir_rd", 3'h6, porte_dir_read);
		tick(8);
		chk("pd_in", 3'h3, portd_input);
		chk("psc_in", 3'h2, {1'h0, psc0_digital_in, psc2_digital_in});
	endtask : t_plain
	task t_freeze;
		clk_en = 1'h0;
		portd_dir = 3'h2;
		tick(3);
		chk("frozen_oe", 3'h5, portd_pad_oe);
		clk_en = 1'h1;
		tick(2);
		chk("thawed_oe", 3'h2, portd_pad_oe);
	endtask : t_freeze
	task t_divided_clock_out;
		{clock_output_fuse, divided_clock_out, chip_in_reset} = 3'h7;
		tick(3);
		chk("divided_clock_out_hi", 3'h3, {1'h0, portd_pad_oe[1], portd_pad_out[1]});
		divided_clock_out = 1'h0;
		tick(3);
		chk("divided_clock_out_lo", 3'h2, {1'h0, portd_pad_oe[1], portd_pad_out[1]});
		{clock_output_fuse, chip_in_reset, divided_clock_out} = 3'h3;
		tick(2);
		chk("divided_clock_out_rst", 3'h3, {1'h0, portd_pad_oe[1], portd_pad_out[1]});
		{clock_output_fuse, chip_in_reset} = 2'h0;
	endtask : t_divided_clock_out
	task t_spi_master;
		{spi_unit_enable, spi_master_select, spi_pin_select, portd_dir, portd_value} = {3'h7, 3'h7, 3'h5};
		tick(2);
		chk("master", 3'h5, {portd_pad_oe[0], portd_pad_oe[2], portd_pullup[2]});
		tick(6);
		chk("miso_in", 3'h1, {2'h0, spi_miso_in});
		{portd_dir[0], psc0_output0, psc0_output0_enable} = 3'h3;
		tick(2);
		chk("psc", 3'h3, {1'h0, portd_pad_oe[0], portd_pad_out[0]});
		psc0_output0_enable = 1'h0;
	endtask : t_spi_master
	task t_spi_slave;
		{spi_master_select, spi_miso_out, portd_dir, portd_value} = {2'h1, 3'h5, 3'h1};
		tick(2);
		chk("slave_oe", 3'h4, portd_pad_oe);
		chk("slave_pu", 3'h3, {1'h0, portd_pad_out[2], portd_pullup[0]});
		{d_ext_en, d_ext} = {3'h1, 3'h0};
		for (int i = 0; i < 12 && spi_slave_selected !== 1'h1; i++) tick(1);
		chk("ss_low", 3'h1, {2'h0, spi_slave_selected});
		d_ext_en = 3'h0;
		for (int i = 0; i < 12 && spi_slave_selected !== 1'h0; i++) tick(1);
		chk("ss_high", 3'h0, {2'h0, spi_slave_selected});
		spi_unit_enable = 1'h0;
	endtask : t_spi_slave
	task t_timers;
		{timer1_compare_a_enable, timer1_compare_a_out, timer0_compare_b_enable, timer0_compare_b_out} = 4'hF;
		{portd_dir, porte_dir, portd_value, porte_value} = {3'h4, 3'h2, 6'h0};
		tick(2);
		chk("oc_on", 3'h3, {1'h0, portd_pad_out[2] & portd_pad_oe[2], porte_pad_out[1] & porte_pad_oe[1]});
		{portd_dir, porte_dir} = 6'h0;
		tick(2);
		chk("oc_off", 3'h0, {1'h0, portd_pad_oe[2], porte_pad_oe[1]});
		{timer1_compare_a_enable, timer0_compare_b_enable} = 2'h0;
	endtask : t_timers
	task t_osc;
		porte_dir = 3'h7;
		for (int s = 0; s < 4; s++) begin
			clk_source = pdeo_clk_src_type'(s);
			tick(2);
			chk("osc_oe", {s != 1 && s != 2, s == 0, 1'h1}, porte_pad_oe);
			chk("osc_claim", {2'h0, s != 0}, {2'h0, osc_pins_claimed});
		end
		clk_source = PDEO_CLK_RC;
	endtask : t_osc
	task t_reset_pin;
		{reset_pin_disable_fuse, porte_value, e_ext_en, e_ext} = {1'h0, 3'h7, 3'h1, 3'h0};
		tick(2);
		chk("rst_pin", 3'h0, {porte_dir_read[0], porte_value_read[0], porte_pad_oe[0]});
		for (int i = 0; i < 12 && external_reset_req !== 1'h1; i++) tick(1);
		chk("rst_req", 3'h1, {2'h0, external_reset_req});
		chk("rst_in", 3'h0, {2'h0, porte_input[0]});
		{reset_pin_disable_fuse, e_ext_en} = {1'h1, 3'h0};
	endtask : t_reset_pin
	initial begin
		#20000;
		fail_count++;
		end_sim;
	end
	initial begin
		{portd_dir, portd_value, porte_dir, porte_value, d_ext, d_ext_en, e_ext, e_ext_en} = 24'h0;
		{clock_output_fuse, chip_in_reset, divided_clock_out, spi_unit_enable, spi_master_select} = 5'h0;
		{spi_pin_select, spi_miso_out, timer1_compare_a_out, timer1_compare_a_enable, psc0_output0} = 5'h0;
		{timer0_compare_b_out, timer0_compare_b_enable, psc0_output0_enable, reset_pin_disable_fuse} = 4'h1;
		clk_source = PDEO_CLK_RC;
		tick(5);
		rst = 1'h0;
		t_plain;
		t_freeze;
		t_divided_clock_out;
		t_spi_master;
		t_spi_slave;
		t_timers;
		t_osc;
		t_reset_pin;
		end_sim;
	end
endmodule : pdeo_override_tb
`default_nettype wire
